//--- rtl/trap_ctrl.sv
// trap priority control: ranks exceptions and interrupts between
// instructions and issues one trap type code
// assumes all inputs are synchronous to aclk; instr_boundary marks the
// gap between two instructions and requests stand during it
module trap_ctrl import trap_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  input  wire logic        instr_boundary,
  input  wire exc_req_t    exc,
  input  wire logic [2:0]  current_window_pointer,
  input  wire fp_event_t   fp_ev,
  input  wire logic [15:1] irq_pending,
  output logic             trap_valid,
  output logic [7:0]       trap_type_code,
  output logic             restart_at_zero,
  output logic [15:1]      irq_ack,
  output logic             fp_commit,
  output logic             error_mode,
  output logic             global_trap_enable,
  output logic             supervisor
);

  // ****************************************************
  // state
  // ****************************************************
  logic             et_reg, s_reg, aw_got_reg, w_got_reg, wr_fire, wr_ctrl, wr_fp, wr_mp, wr_win;
  logic             wr_hit, step, take_reset, sync_any, fp_trap_req, win_valid, irq_take, sync_take, rd_hit;
  logic [2:0]       ftt_reg, fp_cause, save_tgt, rest_tgt;
  logic [3:0]       pil_reg, win_num, w_strb_reg;
  logic [4:0]       tem_reg, acc_reg;
  logic [7:0]       wim_reg, aw_addr_reg, sync_code;
  logic [15:1]      irq_mask_bits, irq_priority_level_bits;
  logic [31:0]      w_data_reg, wmask, rd_word;
  logic [NSYNC-1:0] req;
  core_mode_t       mode_reg;

  // ****************************************************
  // decision between instructions
  // ****************************************************
  // error mode halts the boundary stepping; only a reset request leaves it
  assign step       = ce & instr_boundary & (mode_reg == MODE_RUN) & ~exc.reset_req;
  assign take_reset = ce & exc.reset_req;
  assign save_tgt   = current_window_pointer - 3'h1;
  assign rest_tgt   = current_window_pointer + 3'h1;

  always_comb begin
    fp_cause = FTT_NONE;
    if (fp_ev.hw_err) begin
      fp_cause = FTT_HW;
    end else if (fp_ev.seq_err) begin
      fp_cause = FTT_SEQ;
    end else if (fp_ev.unimpl) begin
      fp_cause = FTT_UNIMPLEMENTED_INSTR;
    end else if (fp_ev.unfinished) begin
      fp_cause = FTT_UNFIN;
    end else if (|(fp_ev.ieee & tem_reg)) begin
      fp_cause = FTT_IEEE;
    end
  end
  assign fp_trap_req = fp_ev.valid & (fp_cause != FTT_NONE);

  assign req[0]  = exc.write_err;
  assign req[1]  = exc.fetch_err;
  assign req[2]  = exc.priv_instr & ~s_reg;
  assign req[3]  = exc.illegal_instr;
  assign req[4]  = exc.fp_absent;
  assign req[5]  = exc.cp_absent;
  assign req[6]  = exc.watch_hit;
  assign req[7]  = exc.save_req & wim_reg[save_tgt];
  assign req[8]  = exc.restore_req & wim_reg[rest_tgt];
  assign req[9]  = exc.regfile_err;
  assign req[10] = exc.misaligned;
  assign req[11] = fp_trap_req;
  assign req[12] = exc.data_err;
  assign req[13] = exc.tag_ovf;
  assign req[14] = exc.div_zero;
  assign req[15] = exc.soft_trap;

  sync_prio u_sync (
    .req      (req),
    .soft_num (exc.soft_num),
    .any      (sync_any),
    .code     (sync_code)
  );

  irq_pick u_irq (
    .pend      (irq_pending),
    .mask      (irq_mask_bits),
    .level     (irq_priority_level_bits),
    .win_valid (win_valid),
    .win_num   (win_num)
  );

  // interrupts rank below every synchronous trap
  assign sync_take = step & sync_any & et_reg;
  assign irq_take  = step & ~sync_any & et_reg & win_valid & (win_num > pil_reg);

  // ****************************************************
  // trap outputs
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trap_valid      <= 1'b0;
      trap_type_code  <= TT_RESET;
      restart_at_zero <= 1'b0;
      irq_ack         <= '0;
    end else if (ce) begin
      trap_valid      <= take_reset | sync_take | irq_take;
      restart_at_zero <= take_reset;
      irq_ack         <= '0;
      if (take_reset) begin
        trap_type_code <= TT_RESET;
      end else if (sync_take) begin
        trap_type_code <= sync_code;
      end else if (irq_take) begin
        trap_type_code <= TT_IRQ_BASE | {4'h0, win_num};
        irq_ack[win_num] <= 1'b1;
      end
    end
  end

  // lower requests are not remembered here; the sources keep them up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= MODE_RUN;
    end else if (take_reset) begin
      mode_reg <= MODE_RUN;
    end else if (step & sync_any & ~et_reg) begin
      mode_reg <= MODE_ERROR;
    end
  end

  // ****************************************************
  // control register: trap enable, supervisor, threshold
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      et_reg  <= ET_RST;
      s_reg   <= S_RST;
      pil_reg <= PIL_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        if (w_strb_reg[0]) begin
          et_reg <= w_data_reg[CTRL_ET];
          s_reg  <= w_data_reg[CTRL_S];
        end
        if (w_strb_reg[1]) begin
          pil_reg <= w_data_reg[CTRL_PIL +: 4];
        end
      end
      // a trap taken in the same cycle outranks software
      if (take_reset | sync_take | irq_take) begin
        et_reg <= 1'b0;
        s_reg  <= 1'b1;
      end
    end
  end

  // ****************************************************
  // floating-point mask, accrued flags and cause
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tem_reg   <= '0;
      acc_reg   <= '0;
      ftt_reg   <= FTT_NONE;
      fp_commit <= 1'b0;
    end else if (ce) begin
      fp_commit <= step & fp_ev.valid & ~fp_trap_req;
      if (wr_fp & w_strb_reg[0]) begin
        tem_reg <= w_data_reg[FP_TEM +: 5];
      end
      // flags clear by writing one; a new flag in the same cycle wins
      if (wr_fp & w_strb_reg[1]) begin
        acc_reg <= (acc_reg & ~w_data_reg[FP_ACC +: 5])
                 | (step & fp_ev.valid & ~fp_trap_req ? fp_ev.ieee : 5'h00);
      end else if (step & fp_ev.valid & ~fp_trap_req) begin
        acc_reg <= acc_reg | fp_ev.ieee;
      end
      if (step & fp_trap_req) begin
        ftt_reg <= fp_cause;
      end
    end
  end

  // ****************************************************
  // interrupt mask, level and window mask
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_bits           <= MASK_RST;
      irq_priority_level_bits <= '0;
      wim_reg                 <= '0;
    end else if (ce) begin
      if (wr_mp) begin
        irq_mask_bits <= (irq_mask_bits & ~wmask[MP_MASK + 1 +: 15])
                       | (w_data_reg[MP_MASK + 1 +: 15] & wmask[MP_MASK + 1 +: 15]);
        irq_priority_level_bits <= (irq_priority_level_bits & ~wmask[MP_LEVEL + 1 +: 15])
                                 | (w_data_reg[MP_LEVEL + 1 +: 15] & wmask[MP_LEVEL + 1 +: 15]);
      end
      if (wr_win & w_strb_reg[0]) begin
        wim_reg <= w_data_reg[7:0];
      end
    end
  end

  // ****************************************************
  // axi4-lite write channel
  // ****************************************************
  assign s_awready = ce & ~aw_got_reg & ~s_bvalid;
  assign s_wready  = ce & ~w_got_reg & ~s_bvalid;
  assign wr_fire   = ce & aw_got_reg & w_got_reg & ~s_bvalid;
  assign wr_ctrl   = wr_fire & (aw_addr_reg == OFS_CTRL);
  assign wr_fp     = wr_fire & (aw_addr_reg == OFS_FP);
  assign wr_mp     = wr_fire & (aw_addr_reg == OFS_IRQMP);
  assign wr_win    = wr_fire & (aw_addr_reg == OFS_WIN);
  assign wr_hit    = wr_ctrl | wr_fp | wr_mp | wr_win | (aw_addr_reg == OFS_STATUS);
  assign wmask     = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_got_reg   <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      s_bvalid    <= 1'b0;
      s_bresp     <= RESP_OKAY;
    end else if (ce) begin
      if (s_awvalid & s_awready) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= {s_awaddr[7:2], 2'b00};
      end
      if (s_wvalid & s_wready) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_wdata;
        w_strb_reg <= s_wstrb;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        s_bvalid   <= 1'b1;
        s_bresp    <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bvalid & s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************
  // axi4-lite read channel
  // ****************************************************
  assign s_arready = ce & ~s_rvalid;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case ({s_araddr[7:2], 2'b00})
      OFS_CTRL: begin
        rd_word[CTRL_ET]       = et_reg;
        rd_word[CTRL_S]        = s_reg;
        rd_word[CTRL_PIL +: 4] = pil_reg;
      end
      OFS_FP: begin
        rd_word[FP_TEM +: 5]   = tem_reg;
        rd_word[FP_ACC +: 5]   = acc_reg;
        rd_word[FP_CAUSE +: 3] = ftt_reg;
      end
      OFS_IRQMP: begin
        rd_word[MP_MASK + 1 +: 15]  = irq_mask_bits;
        rd_word[MP_LEVEL + 1 +: 15] = irq_priority_level_bits;
      end
      OFS_WIN: begin
        rd_word[7:0] = wim_reg;
      end
      OFS_STATUS: begin
        rd_word[7:0]      = trap_type_code;
        rd_word[ST_ERROR] = (mode_reg == MODE_ERROR);
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= '0;
      s_rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (s_arvalid & s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_word;
        s_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rvalid & s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  assign error_mode         = (mode_reg == MODE_ERROR);
  assign global_trap_enable = et_reg;
  assign supervisor         = s_reg;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  trap_needs_et_a: assert property (
    trap_valid && !restart_at_zero && $past(ce) |-> $past(et_reg))
    else $error("trap taken with traps disabled");
  one_ack_a: assert property (
    $onehot0(irq_ack) && (irq_ack == '0 || trap_valid))
    else $error("more than one interrupt acknowledged");
  error_entry_a: assert property (
    step && sync_any && !et_reg |=> error_mode && !trap_valid)
    else $error("disabled exception did not enter error mode");
  irq_threshold_a: assert property (
    |irq_ack |-> trap_type_code > {4'h1, $past(pil_reg)})
    else $error("interrupt at or below threshold taken");
  irq_gate_a: assert property (
    ce && !et_reg |=> irq_ack == '0)
    else $error("interrupt taken while traps disabled");
  reset_trap_a: assert property (
    take_reset |=> trap_valid && restart_at_zero && trap_type_code == TT_RESET
                   && !global_trap_enable && supervisor)
    else $error("reset trap wrong");
  sync_first_a: assert property (
    sync_take |=> trap_valid && trap_type_code == $past(sync_code) && irq_ack == '0)
    else $error("synchronous trap not taken first");
  fp_trap_hold_a: assert property (
    step && fp_trap_req && !wr_fp |=> !fp_commit && acc_reg == $past(acc_reg))
    else $error("trapping fp exception changed state");
  fp_accrue_a: assert property (
    step && fp_ev.valid && !fp_trap_req |=> fp_commit && (acc_reg & $past(fp_ev.ieee)) == $past(fp_ev.ieee))
    else $error("masked fp exception not accrued");
  level_rank_a: assert property (
    |irq_ack && |$past(irq_pending & irq_mask_bits & irq_priority_level_bits)
    |-> |($past(irq_priority_level_bits) & irq_ack))
    else $error("low level interrupt beat high level");

  reset_seen_c: cover property (take_reset ##1 trap_valid);
  irq_seen_c:   cover property (irq_take ##1 |irq_ack);
  error_seen_c: cover property (step && sync_any && !et_reg ##1 error_mode);
  fp_seen_c:    cover property (step && fp_ev.valid && !fp_trap_req ##1 fp_commit);

endmodule // trap_ctrl

//--- rtl/trap_pkg.sv
// constants, types and encodings of the trap priority control block
// assumes one 250 MHz core clock and a 32-bit axi4-lite register bus
package trap_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_FP     = 8'h04;
  localparam logic [7:0]  OFS_IRQMP  = 8'h08;
  localparam logic [7:0]  OFS_WIN    = 8'h0C;
  localparam logic [7:0]  OFS_STATUS = 8'h10;
  localparam int          CTRL_ET    = 0;
  localparam int          CTRL_S     = 1;
  localparam int          CTRL_PIL   = 8;
  localparam int          FP_TEM     = 0;
  localparam int          FP_ACC     = 8;
  localparam int          FP_CAUSE   = 16;
  localparam int          MP_MASK    = 0;
  localparam int          MP_LEVEL   = 16;
  localparam int          ST_ERROR   = 8;
  localparam logic        ET_RST     = 1'b0;
  localparam logic        S_RST      = 1'b1;
  localparam logic [3:0]  PIL_RST    = 4'h0;
  localparam logic [15:1] MASK_RST   = 15'h0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************************
  // trap codes
  // ****************************************************
  localparam logic [7:0]  TT_RESET   = 8'h00;
  localparam logic [7:0]  TT_IRQ_BASE = 8'h10;
  localparam logic [7:0]  TT_SOFT_BASE = 8'h80;
  localparam int          NSYNC      = 16;
  localparam int          IDX_SOFT   = 15;
  // index 0 is the most urgent; fp before cp and overflow before underflow
  localparam logic [7:0]  SYNC_CODES [NSYNC] = '{
    8'h2B, 8'h01, 8'h03, 8'h02, 8'h04, 8'h24, 8'h0B, 8'h05,
    8'h06, 8'h20, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h2A, 8'h80};
  localparam logic [2:0]  FTT_NONE   = 3'h0;
  localparam logic [2:0]  FTT_IEEE   = 3'h1;
  localparam logic [2:0]  FTT_UNFIN  = 3'h2;
  localparam logic [2:0]  FTT_UNIMPLEMENTED_INSTR  = 3'h3;
  localparam logic [2:0]  FTT_SEQ    = 3'h4;
  localparam logic [2:0]  FTT_HW     = 3'h5;

  typedef enum logic {MODE_RUN, MODE_ERROR} core_mode_t;

  typedef struct packed {
    logic       reset_req;
    logic       write_err;
    logic       fetch_err;
    logic       priv_instr;
    logic       illegal_instr;
    logic       fp_absent;
    logic       cp_absent;
    logic       watch_hit;
    logic       save_req;
    logic       restore_req;
    logic       regfile_err;
    logic       misaligned;
    logic       data_err;
    logic       tag_ovf;
    logic       div_zero;
    logic       soft_trap;
    logic [6:0] soft_num;
  } exc_req_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] ieee;
    logic       unfinished;
    logic       unimpl;
    logic       seq_err;
    logic       hw_err;
  } fp_event_t;

endpackage

//--- rtl/sync_prio.sv
// fixed-priority pick among synchronous trap requests
// assumes request bits are already qualified by the caller
module sync_prio import trap_pkg::*; (
  input  wire logic [NSYNC-1:0] req,
  input  wire logic [6:0]       soft_num,
  output logic                  any,
  output logic [7:0]            code
);
  always_comb begin
    any  = |req;
    code = 8'h00;
    // walk from least urgent so the most urgent overwrites
    for (int i = NSYNC - 1; i >= 0; i--) begin
      if (req[i]) begin
        code = (i == IDX_SOFT) ? (TT_SOFT_BASE | {1'b0, soft_num}) : SYNC_CODES[i];
      end
    end
  end
endmodule // sync_prio

//--- rtl/irq_pick.sv
// picks the interrupt that wins by level, then by number
// assumes pending bits are held by the interrupt controller until acked
module irq_pick import trap_pkg::*; (
  input  wire logic [15:1] pend,
  input  wire logic [15:1] mask,
  input  wire logic [15:1] level,
  output logic             win_valid,
  output logic [3:0]       win_num
);
  logic [15:1] hi;
  logic [15:1] lo;
  logic [15:1] sel;

  for (genvar i = 1; i <= 15; i++) begin : g_cand
    assign hi[i] = pend[i] & mask[i] & level[i];
    assign lo[i] = pend[i] & mask[i] & ~level[i];
  end

  always_comb begin
    sel       = (|hi) ? hi : lo;
    win_valid = |sel;
    win_num   = 4'h0;
    for (int i = 1; i <= 15; i++) begin
      if (sel[i]) begin
        win_num = 4'(i);
      end
    end
  end
endmodule // irq_pick

//--- verif/irq_source.sv
// far-side model: interrupt controller that keeps requests pending
// assumes irq_ack is a one-cycle pulse from the trap block
module irq_source (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:1] raise,
  input  wire logic [15:1] irq_ack,
  output logic      [15:1] irq_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  // **********
  // pending
  // **********
  // only the acked bit clears; losers must stay up or they are lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pending <= '0;
    end else begin
      irq_pending <= (irq_pending | raise) & ~irq_ack;
    end
  end
endmodule // irq_source

//--- verif/trap_priority_control_test.sv
// self-checking bench of the trap block, one task a scenario
// assumes trap_ctrl and irq_source; ce and wstrb held constant
module trap_priority_control_test import trap_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, ce = 1, instr_boundary = 0;
  logic [7:0]  s_awaddr = '0, s_araddr = '0, trap_type_code;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic [31:0] s_wdata = '0, s_rdata;
  logic [3:0]  s_wstrb = 4'hF;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, trap_valid, restart_at_zero;
  logic        fp_commit, error_mode, global_trap_enable, supervisor;
  logic [1:0]  s_bresp, s_rresp;
  exc_req_t    exc = '0;
  fp_event_t   fp_ev = '0;
  logic [2:0]  current_window_pointer = 3'h0;
  logic [15:1] irq_pending, irq_ack, raise = '0;
  int          miscompares = 0, comparisons = 0, cycles = 0;

  trap_ctrl dut (.aclk, .aresetn, .ce, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready, .instr_boundary, .exc, .current_window_pointer, .fp_ev, .irq_pending,
    .trap_valid, .trap_type_code, .restart_at_zero, .irq_ack, .fp_commit, .error_mode,
    .global_trap_enable, .supervisor);
  irq_source model (.aclk, .aresetn, .raise, .irq_ack, .irq_pending);

  // **********
  // helpers
  // **********
  initial begin
    forever #2 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // generous ceiling: the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // handshakes judged at the falling edge, where inputs are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w, b;
    logic [1:0] rs;
    b = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1;
    s_wvalid <= 1;
    s_bready <= 1;
    while (!b) begin
      @(negedge aclk);
      aw = s_awvalid && s_awready;
      w = s_wvalid && s_wready;
      b = s_bvalid && s_bready;
      rs = s_bresp;
      @(posedge aclk);
      if (aw) s_awvalid <= 0;
      if (w) s_wvalid <= 0;
      if (b) s_bready <= 0;
    end
    chk("bresp", r, rs);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    logic ar, v;
    logic [31:0] d;
    logic [1:0] rs;
    v = 0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1;
    s_rready <= 1;
    while (!v) begin
      @(negedge aclk);
      ar = s_arvalid && s_arready;
      v = s_rvalid && s_rready;
      d = s_rdata;
      rs = s_rresp;
      @(posedge aclk);
      if (ar) s_arvalid <= 0;
      if (v) s_rready <= 0;
    end
    chk("rdata", e, d);
    chk("rresp", r, rs);
  endtask

  // one boundary cycle; the answer stands in the following cycle only
  task automatic tk(input exc_req_t e, input fp_event_t f, input logic v, input logic [7:0] c);
    @(posedge aclk);
    instr_boundary <= 1;
    exc <= e;
    fp_ev <= f;
    @(posedge aclk);
    instr_boundary <= 0;
    exc <= '0;
    fp_ev <= '0;
    @(negedge aclk);
    chk("trap_valid", v, trap_valid);
    if (v) chk("trap_type_code", c, trap_type_code);
  endtask

  // **********
  // scenarios
  // **********
  task automatic reset_and_halt();
    exc_req_t e;
    e = '0;
    rd(OFS_CTRL, 32'h2, RESP_OKAY);
    rd(OFS_IRQMP, 32'h0, RESP_OKAY);
    wr(8'h14, 32'hFFFFFFFF, RESP_SLVERR);
    rd(8'h14, 32'h0, RESP_SLVERR);
    e.misaligned = 1;
    tk(e, '0, 0, 8'h00);
    chk("error_mode", 1, error_mode);
    e = '0;
    e.reset_req = 1;
    tk(e, '0, 1, 8'h00);
    chk("restart", 1, restart_at_zero);
    chk("error_mode", 0, error_mode);
    chk("et_s", 2'b01, {global_trap_enable, supervisor});
  endtask

  // every cause but the fp trap raised together with all less urgent ones
  task automatic sync_scan();
    logic [7:0] codes [15] = '{8'h2B, 8'h01, 8'h03, 8'h02, 8'h04, 8'h24, 8'h0B, 8'h05,
                               8'h06, 8'h20, 8'h07, 8'h09, 8'h0A, 8'h2A, 8'h85};
    exc_req_t e;
    wr(OFS_WIN, 32'hFF, RESP_OKAY);
    for (int i = 0; i < 15; i++) begin
      wr(OFS_CTRL, 32'h1, RESP_OKAY);
      e = {1'b0, 15'h7FFF >> i, 7'h05};
      tk(e, '0, 1, codes[i]);
      chk("et_s", 2'b01, {global_trap_enable, supervisor});
    end
  endtask

  task automatic fp_modes();
    fp_event_t f;
    f = '0;
    f.valid = 1;
    f.ieee = 5'h01;
    wr(OFS_FP, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    tk('0, f, 0, 8'h00);
    chk("fp_commit", 1, fp_commit);
    rd(OFS_FP, 32'h100, RESP_OKAY);
    wr(OFS_FP, 32'h1, RESP_OKAY);
    tk('0, f, 1, 8'h08);
    chk("fp_commit", 0, fp_commit);
    rd(OFS_FP, 32'h00010101, RESP_OKAY);
    f.hw_err = 1;
    f.unimpl = 1;
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    tk('0, f, 1, 8'h08);
    rd(OFS_FP, 32'h00050101, RESP_OKAY);
  endtask

  // only the window the pointer moves onto counts; supervisor blocks the privilege trap
  task automatic window_priv();
    exc_req_t e;
    e = '0;
    wr(OFS_WIN, 32'h01, RESP_OKAY);
    current_window_pointer <= 3'h1;
    rd(OFS_WIN, 32'h01, RESP_OKAY);
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    e.restore_req = 1;
    e.priv_instr = 1;
    tk(e, '0, 0, 8'h00);
    e = '0;
    e.save_req = 1;
    tk(e, '0, 1, 8'h05);
    rd(OFS_STATUS, 32'h05, RESP_OKAY);
  endtask

  // irq 3 on level 1 outranks irq 9 on level 0; 9 must survive
  task automatic irq_levels();
    wr(OFS_IRQMP, 32'h00080208, RESP_OKAY);
    wr(OFS_CTRL, 32'h203, RESP_OKAY);
    @(posedge aclk);
    raise[3] <= 1;
    raise[9] <= 1;
    @(posedge aclk);
    raise <= '0;
    tk('0, '0, 1, 8'h13);
    chk("irq_ack", 32'h4, irq_ack);
    wr(OFS_CTRL, 32'h903, RESP_OKAY);
    tk('0, '0, 0, 8'h00);
    wr(OFS_CTRL, 32'h802, RESP_OKAY);
    tk('0, '0, 0, 8'h00);
    wr(OFS_CTRL, 32'h803, RESP_OKAY);
    tk('0, '0, 1, 8'h19);
    chk("irq_ack", 32'h100, irq_ack);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    reset_and_halt();
    sync_scan();
    fp_modes();
    irq_levels();
    window_priv();
    end_sim();
  end
endmodule // trap_priority_control_test
